//--- hrs_pkg.sv
// Purpose: Shared constants and types for the hardware reset and strap control block
// Assumes: 50 MHz core clock, one clock domain
// Notes: Port counts and bank sizes are fixed at the documented values
package hrs_pkg;
    // Clock rate in kHz and reset hold times in microseconds
    localparam int CLK_KHZ = 50000;
    localparam int POR_HOLD_US = 150;
    localparam int WARM_HOLD_US = 4;
    // Least hold times round up to whole cycles
    localparam int POR_HOLD_CYC = (POR_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int WARM_HOLD_CYC = (WARM_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int HOLD_W = 13;
    localparam int NUM_PORTS = 12;
    localparam int STAT_REGS = 17;
    localparam int ATTR_BANKS = 15;
    localparam int ATTR_REGS = 17;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [NUM_PORTS-1:0] PORTS_ALL_ON = 12'hFFF;
    localparam logic [NUM_PORTS-1:0] PORTS_ALL_OFF = 12'h000;
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 13'h0000;
    localparam logic [HOLD_W-1:0] HOLD_ONE = 13'h0001;
    localparam logic BUS_MODE_SYNC = 1'b0;
    localparam logic BUS_MODE_ASYNC = 1'b1;

    // Reset sequencer states
    typedef enum logic [1:0] {
        HRS_IN_RESET,
        HRS_RUN
    } hrs_state_t;

    // Processor preset write to a statistics or attribute word
    typedef struct packed {
        logic valid;
        logic attr_sel;
        logic [3:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } hrs_preset_t;

    // Inactive-level view of the device outputs
    typedef struct packed {
        logic ctl_active_high;
        logic ctl_active_low_n;
        logic analog_idle;
        logic bidir_oe;
        logic receive_inversion_indicator;
    } hrs_out_t;
endpackage : hrs_pkg

//--- hrs_reset_ctrl.sv
// Purpose: Hardware reset entry, strap capture and preset gating for a multiport repeater
// Assumes: reset pin and straps are asynchronous board levels, synchronised here
// Notes: Statistics and attribute storage is outside reset and powers up unknown
`timescale 1ns/1ps

// Function
// R1 - Low reset pin holds device in reset
// R2 - Board holds reset low 150us/4us minimum
// R3 - Reset loads defaults into covered registers
// R4 - Reset idles outputs, floats bidirectional pins
// R5 - Receive inversion indicator driven high in reset
// R6 - Board synchronises reset to clock, sync mode
// R7 - Reset leaves statistics and attribute banks alone
// R8 - Statistics and attribute words power up arbitrary
// R9 - Presets accepted in software reset or disabled
// R10 - Bus mode strap sampled during reset
// R11 - Port default strap sets initial port enables
// R12 - After reset software alone controls ports
// R13 - Sync mode shares one master clock
// R14 - Release synchronised, straps latched at release
module hrs_reset_ctrl
    import hrs_pkg::*;
(
    input wire logic core_clk, // R13
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic bus_mode_strap,
    input wire logic port_default_strap,
    input wire logic soft_reset,
    input wire logic port_wr,
    input wire logic [NUM_PORTS-1:0] port_wr_data,
    input wire hrs_preset_t preset,
    input wire logic [3:0] rd_bank,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_attr_sel,
    output logic [DATA_W-1:0] rd_data,
    output logic preset_taken,
    output logic in_reset,
    output logic bus_mode_async,
    output logic [NUM_PORTS-1:0] port_enable,
    output logic [NUM_PORTS-1:0] port_drive_oe,
    output hrs_out_t out_levels,
    output logic short_reset_seen
);
    // Two-stage synchronisers for pin and strap levels
    logic rst_s1_q, rst_s2_q;
    logic mode_s1_q, mode_s2_q;
    logic pdef_s1_q, pdef_s2_q;
    hrs_state_t state_q, state_d;
    logic [NUM_PORTS-1:0] port_en_q, port_en_d;
    logic mode_q, mode_d;
    logic [HOLD_W-1:0] hold_q, hold_d;
    logic first_q;
    logic short_q;
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] stat_mem [STAT_REGS];
    logic [DATA_W-1:0] attr_mem [ATTR_BANKS][ATTR_REGS];

    wire pin_low = ~rst_s2_q;
    wire releasing = (state_q == HRS_IN_RESET) && !pin_low;
    wire [HOLD_W-1:0] need_cyc = first_q ? HOLD_W'(POR_HOLD_CYC) : HOLD_W'(WARM_HOLD_CYC);
    wire attr_port_off = (preset.bank < 4'(NUM_PORTS)) ? !port_en_q[preset.bank] : 1'b1;
    wire preset_ok = preset.valid && !pin_low && (state_q == HRS_RUN)
                     && (soft_reset || (preset.attr_sel && attr_port_off)); // R9
    wire attr_hit = preset.attr_sel && (preset.bank < 4'(ATTR_BANKS))
                    && (preset.addr < ADDR_W'(ATTR_REGS));
    wire stat_hit = !preset.attr_sel && (preset.addr < ADDR_W'(STAT_REGS));

    // Synchronisers; reset pin idles in reset until it has been seen high
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= reset_pin_n;
            rst_s2_q <= rst_s1_q; // R14
        end
        mode_s1_q <= bus_mode_strap;
        mode_s2_q <= mode_s1_q;
        pdef_s1_q <= port_default_strap;
        pdef_s2_q <= pdef_s1_q;
    end

    // Sequencer: stay in reset while the pin is low, straps latched at release
    always_comb begin
        state_d = state_q;
        port_en_d = port_en_q;
        mode_d = mode_q;
        if (pin_low) begin
            state_d = HRS_IN_RESET; // R1
            port_en_d = PORTS_ALL_ON; // R3
        end else if (releasing) begin
            state_d = HRS_RUN;
            mode_d = mode_s2_q; // R10
            port_en_d = pdef_s2_q ? PORTS_ALL_ON : PORTS_ALL_OFF; // R11
        end else if (port_wr) begin
            port_en_d = port_wr_data; // R12
        end
    end

    // Hold-time monitor flags a reset shorter than the board should give
    always_comb begin
        hold_d = hold_q;
        if (pin_low && hold_q != {HOLD_W{1'b1}}) begin
            hold_d = hold_q + HOLD_ONE;
        end else if (!pin_low) begin
            hold_d = HOLD_ZERO;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= HRS_IN_RESET;
            port_en_q <= PORTS_ALL_ON;
            mode_q <= BUS_MODE_SYNC;
            hold_q <= HOLD_ZERO;
            first_q <= 1'b1;
            short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            port_en_q <= port_en_d;
            mode_q <= mode_d;
            hold_q <= hold_d;
            if (releasing) begin
                first_q <= 1'b0;
                short_q <= (hold_q < need_cyc); // R2
            end
        end
    end

    // Storage has no reset on purpose; contents survive hardware reset
    always_ff @(posedge core_clk) begin
        if (preset_ok && stat_hit) begin
            stat_mem[preset.addr] <= preset.data; // R7
        end
        if (preset_ok && attr_hit) begin
            attr_mem[preset.bank][preset.addr] <= preset.data; // R8
        end
    end

    // Registered read port; unmapped words read zero
    wire rd_attr_ok = (rd_bank < 4'(ATTR_BANKS)) && (rd_addr < ADDR_W'(ATTR_REGS));
    wire rd_stat_ok = rd_addr < ADDR_W'(STAT_REGS);
    wire [DATA_W-1:0] rd_sel = rd_attr_sel ? (rd_attr_ok ? attr_mem[rd_bank][rd_addr] : '0)
                                           : (rd_stat_ok ? stat_mem[rd_addr] : '0);
    always_ff @(posedge core_clk) begin
        rd_q <= rd_sel;
    end

    // Outputs: inactive levels while in reset, polarity indicator high
    assign in_reset = pin_low || (state_q == HRS_IN_RESET);
    assign bus_mode_async = mode_q;
    assign port_enable = port_en_q;
    assign port_drive_oe = in_reset ? PORTS_ALL_OFF : port_en_q; // R4 R11
    assign out_levels = '{
        ctl_active_high: 1'b0, // R4
        ctl_active_low_n: 1'b1,
        analog_idle: in_reset,
        bidir_oe: !in_reset,
        receive_inversion_indicator: in_reset // R5
    };
    assign preset_taken = preset_ok && (stat_hit || attr_hit);
    assign rd_data = rd_q;
    assign short_reset_seen = short_q;

    // Checks
    property p_in_reset_follows_pin;
        @(posedge core_clk) disable iff (sys_rst)
            pin_low |=> in_reset && state_q == HRS_IN_RESET;
    endproperty
    a_in_reset_follows_pin: assert property (p_in_reset_follows_pin) // R1
        else $error("device not in reset while pin low");

    property p_oe_off_in_reset;
        @(posedge core_clk) disable iff (sys_rst) in_reset |-> port_drive_oe == PORTS_ALL_OFF;
    endproperty
    a_oe_off_in_reset: assert property (p_oe_off_in_reset) // R4
        else $error("port drivers on during reset");

    property p_pol_high;
        @(posedge core_clk) disable iff (sys_rst)
            in_reset |-> out_levels.receive_inversion_indicator && !out_levels.bidir_oe;
    endproperty
    a_pol_high: assert property (p_pol_high) // R5
        else $error("indicator not high in reset");

    property p_mode_latch;
        @(posedge core_clk) disable iff (sys_rst) releasing |=> bus_mode_async == $past(mode_s2_q);
    endproperty
    a_mode_latch: assert property (p_mode_latch) // R10
        else $error("bus mode not latched at release");

    property p_port_default;
        @(posedge core_clk) disable iff (sys_rst)
            releasing && !pdef_s2_q |=> port_enable == PORTS_ALL_OFF;
    endproperty
    a_port_default: assert property (p_port_default) // R11
        else $error("ports not disabled by strap");

    property p_sw_only;
        @(posedge core_clk) disable iff (sys_rst)
            !in_reset && !pin_low && !port_wr |=> $stable(port_enable) || $past(releasing);
    endproperty
    a_sw_only: assert property (p_sw_only) // R12
        else $error("port enable changed without write");

    property p_mode_stable;
        @(posedge core_clk) disable iff (sys_rst) state_q == HRS_RUN && !pin_low |=> $stable(mode_q);
    endproperty
    a_mode_stable: assert property (p_mode_stable) // R14
        else $error("bus mode changed outside release");

    property p_no_preset_in_reset;
        @(posedge core_clk) disable iff (sys_rst) in_reset |-> !preset_taken;
    endproperty
    a_no_preset_in_reset: assert property (p_no_preset_in_reset) // R9
        else $error("preset taken during hardware reset");

    // A low pin brings the port enables back to their default next edge
    property p_ports_on_in_reset;
        @(posedge core_clk) disable iff (sys_rst) pin_low |=> port_enable == PORTS_ALL_ON;
    endproperty
    a_ports_on_in_reset: assert property (p_ports_on_in_reset) // R3
        else $error("port enables not at default in reset");

    // Board reset also clears the latched mode and keeps the device in reset
    property p_board_reset_defaults;
        @(posedge core_clk) sys_rst |=> bus_mode_async == BUS_MODE_SYNC && in_reset;
    endproperty
    a_board_reset_defaults: assert property (p_board_reset_defaults) // R3
        else $error("defaults not loaded by board reset");

    // Release is the synchroniser depth plus one sequencer edge; a pin that
    // falls again at once may pull the device straight back into reset
    sequence s_pin_rise;
        !rst_s2_q ##1 rst_s2_q;
    endsequence
    sequence s_release_edge;
        in_reset && !pin_low ##1 (!in_reset || pin_low);
    endsequence
    property p_release_timing;
        @(posedge core_clk) disable iff (sys_rst) s_pin_rise |-> s_release_edge;
    endproperty
    a_release_timing: assert property (p_release_timing) // R14
        else $error("reset release not one edge after sync");

    // A high port strap at release turns every port on
    property p_port_default_on;
        @(posedge core_clk) disable iff (sys_rst)
            releasing && pdef_s2_q |=> port_enable == PORTS_ALL_ON;
    endproperty
    a_port_default_on: assert property (p_port_default_on) // R11
        else $error("ports not enabled by strap");

    // Out of reset the analog, bidir and indicator outputs leave their idle levels and drivers follow enables
    property p_run_levels;
        @(posedge core_clk) disable iff (sys_rst)
            !in_reset |-> out_levels.bidir_oe && !out_levels.analog_idle
                          && !out_levels.receive_inversion_indicator;
    endproperty
    a_run_levels: assert property (p_run_levels) // R4 R5
        else $error("outputs idle outside reset");

    property p_run_drive;
        @(posedge core_clk) disable iff (sys_rst) !in_reset |-> port_drive_oe == port_enable;
    endproperty
    a_run_drive: assert property (p_run_drive) // R11
        else $error("port drivers do not follow enables");

    // A software port write lands on the next edge
    property p_write_lands;
        @(posedge core_clk) disable iff (sys_rst)
            !in_reset && port_wr |=> port_enable == $past(port_wr_data);
    endproperty
    a_write_lands: assert property (p_write_lands) // R12
        else $error("port write not applied");

    // Statistics presets need software reset
    property p_stat_needs_soft;
        @(posedge core_clk) disable iff (sys_rst)
            preset.valid && !preset.attr_sel && !soft_reset |-> !preset_taken;
    endproperty
    a_stat_needs_soft: assert property (p_stat_needs_soft) // R9
        else $error("statistics preset taken without software reset");

    property p_stat_soft_taken;
        @(posedge core_clk) disable iff (sys_rst)
            preset.valid && !preset.attr_sel && soft_reset && !in_reset
            && preset.addr < ADDR_W'(STAT_REGS) |-> preset_taken;
    endproperty
    a_stat_soft_taken: assert property (p_stat_soft_taken) // R9
        else $error("statistics preset refused in software reset");

    // Attribute presets follow the port's own enable when software reset is off
    property p_attr_port_on_refused;
        @(posedge core_clk) disable iff (sys_rst)
            preset.valid && preset.attr_sel && !soft_reset
            && preset.bank < 4'(NUM_PORTS) && port_enable[preset.bank] |-> !preset_taken;
    endproperty
    a_attr_port_on_refused: assert property (p_attr_port_on_refused) // R9
        else $error("attribute preset taken on enabled port");

    property p_attr_port_off_taken;
        @(posedge core_clk) disable iff (sys_rst)
            preset.valid && preset.attr_sel && !in_reset
            && preset.bank < 4'(NUM_PORTS) && !port_enable[preset.bank]
            && preset.addr < ADDR_W'(ATTR_REGS) |-> preset_taken;
    endproperty
    a_attr_port_off_taken: assert property (p_attr_port_off_taken) // R9
        else $error("attribute preset refused on disabled port");
endmodule : hrs_reset_ctrl

//--- hrs_board_model.sv
// Purpose: Board reset source and strap pull resistors
// Assumes: Reset pulse is timed on the shared master clock
// Notes: Pin is low from power-up until the first pulse runs out
`timescale 1ns/1ps
module hrs_board_model
    import hrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic pulse_req,
    input wire logic [HOLD_W-1:0] pulse_len,
    input wire logic mode_pull,
    input wire logic ports_pull,
    output logic reset_pin_n,
    output logic bus_mode_strap,
    output logic port_default_strap
);
    logic [HOLD_W-1:0] hold_q = HOLD_ONE;

    // Clocked hold keeps release aligned to the master clock
    always @(posedge core_clk) begin
        if (pulse_req) begin
            hold_q <= pulse_len;
        end else if (hold_q != HOLD_ZERO) begin
            hold_q <= hold_q - HOLD_ONE;
        end
    end

    // Straps are static pulls, never left floating
    assign reset_pin_n = (hold_q == HOLD_ZERO);
    assign bus_mode_strap = mode_pull;
    assign port_default_strap = ports_pull;
endmodule : hrs_board_model

//--- test_hardware_reset_strap_control.sv
// Purpose: Self-checking bench for reset entry, strap capture and presets
// Assumes: Board model drives the pin; notes are compared at the falling edge
// Notes: Power-up hold is the full count, so the run takes about 7900 cycles
`timescale 1ns/1ps
module test_hardware_reset_strap_control;
    import hrs_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, soft_reset = 1'b0, port_wr = 1'b0;
    logic req = 1'b1, xm = 1'b1, xe = 1'b0, rd_attr_sel = 1'b0;
    logic [HOLD_W-1:0] len = HOLD_W'(POR_HOLD_CYC + 20);
    logic [NUM_PORTS-1:0] port_wr_data = PORTS_ALL_OFF, pv, port_enable, port_drive_oe;
    hrs_preset_t preset = '0;
    logic [3:0] rd_bank = 4'h0;
    logic [ADDR_W-1:0] rd_addr = 5'h00;
    logic [DATA_W-1:0] rd_data, d1, d2;
    logic reset_pin_n, bus_mode_strap, port_default_strap, preset_taken, in_reset;
    logic bus_mode_async, short_reset_seen;
    hrs_out_t out_levels;
    logic [15:0] exp_q[$];
    logic [2:0] kind_q[$];
    int errors = 0, samples_checked = 0, cyc = 0;

    always #10 core_clk = ~core_clk;

    hrs_board_model hrs_board_model_i (.core_clk(core_clk), .pulse_req(req),
        .pulse_len(len), .mode_pull(xm), .ports_pull(xe), .reset_pin_n(reset_pin_n),
        .bus_mode_strap(bus_mode_strap), .port_default_strap(port_default_strap));
    hrs_reset_ctrl hrs_reset_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .bus_mode_strap(bus_mode_strap),
        .port_default_strap(port_default_strap), .soft_reset(soft_reset),
        .port_wr(port_wr), .port_wr_data(port_wr_data), .preset(preset),
        .rd_bank(rd_bank), .rd_addr(rd_addr), .rd_attr_sel(rd_attr_sel),
        .rd_data(rd_data), .preset_taken(preset_taken), .in_reset(in_reset),
        .bus_mode_async(bus_mode_async), .port_enable(port_enable),
        .port_drive_oe(port_drive_oe), .out_levels(out_levels),
        .short_reset_seen(short_reset_seen));

    // Output picked by the kind of note
    function automatic logic [15:0] seen(input logic [2:0] k);
        case (k)
            3'h0: seen = {15'h0000, in_reset};
            3'h1: seen = {15'h0000, bus_mode_async};
            3'h2: seen = {4'h0, port_enable};
            3'h3: seen = {4'h0, port_drive_oe};
            3'h4: seen = {11'h000, out_levels};
            3'h5: seen = {15'h0000, preset_taken};
            3'h6: seen = {8'h00, rd_data};
            3'h7: seen = {15'h0000, short_reset_seen};
        endcase
    endfunction : seen

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic note(input logic [2:0] k, input logic [15:0] v);
        kind_q.push_back(k);
        exp_q.push_back(v);
    endtask : note

    // Falling edge lets every rising-edge update settle first
    always @(negedge core_clk) begin
        while (exp_q.size() > 0) begin
            check(seen(kind_q.pop_front()), exp_q.pop_front());
        end
    end

    task automatic observe(input logic m, input logic e, input logic s);
        repeat (4) @(posedge core_clk);
        note(3'h0, 16'h0001);
        note(3'h4, 16'h000D);
        note(3'h3, 16'h0000);
        note(3'h2, 16'h0FFF);
        for (int i = 0; i < 8000 && in_reset !== 1'b0; i++) begin
            @(negedge core_clk);
        end
        @(posedge core_clk);
        note(3'h0, 16'h0000);
        note(3'h1, {15'h0000, m});
        note(3'h2, {4'h0, e ? PORTS_ALL_ON : PORTS_ALL_OFF});
        note(3'h3, {4'h0, e ? PORTS_ALL_ON : PORTS_ALL_OFF});
        note(3'h4, 16'h000A);
        note(3'h7, {15'h0000, s});
    endtask : observe

    task automatic pulse(input logic [HOLD_W-1:0] n, input logic m, input logic e, input logic s);
        @(posedge core_clk);
        req <= 1'b1;
        len <= n;
        xm <= m;
        xe <= e;
        @(posedge core_clk);
        req <= 1'b0;
        observe(m, e, s);
    endtask : pulse

    task automatic put(input logic a, input logic [3:0] b, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] d, input logic ok);
        @(posedge core_clk);
        preset <= '{1'b1, a, b, ad, d};
        note(3'h5, {15'h0000, ok});
        @(posedge core_clk);
        preset.valid <= 1'b0;
    endtask : put

    task automatic get(input logic a, input logic [3:0] b, input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        rd_attr_sel <= a;
        rd_bank <= b;
        rd_addr <= ad;
        @(posedge core_clk);
        note(3'h6, {8'h00, d});
    endtask : get

    task automatic final_report();
        // Notes never compared count against the run
        errors += exp_q.size();
        $display("errors %0d, samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Ceiling sits well above the power-up hold plus the warm resets
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h511D0FC3));
        pv = 12'($urandom());
        d1 = 8'($urandom());
        d2 = 8'($urandom());
        pv[3] = 1'b0;
        pv[4] = 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        req <= 1'b0;
        observe(1'b1, 1'b0, 1'b0);
        // Straps move after release; only software may touch the ports
        @(posedge core_clk);
        port_wr <= 1'b1;
        port_wr_data <= pv;
        xm <= 1'b0;
        xe <= 1'b1;
        @(posedge core_clk);
        port_wr <= 1'b0;
        @(posedge core_clk);
        note(3'h2, {4'h0, pv});
        note(3'h3, {4'h0, pv});
        note(3'h1, 16'h0001);
        put(1'b1, 4'h3, 5'h02, d1, 1'b1);
        put(1'b1, 4'h4, 5'h02, ~d1, 1'b0);
        put(1'b0, 4'h5, 5'h10, d2, 1'b0);
        soft_reset <= 1'b1;
        put(1'b0, 4'h5, 5'h10, d2, 1'b1);
        soft_reset <= 1'b0;
        get(1'b1, 4'h3, 5'h02, d1);
        pulse(HOLD_W'(WARM_HOLD_CYC + 2), 1'b0, 1'b1, 1'b0);
        get(1'b1, 4'h3, 5'h02, d1);
        get(1'b0, 4'h5, 5'h10, d2);
        pulse(HOLD_W'(WARM_HOLD_CYC / 2), 1'b1, 1'b0, 1'b1);
        // Let the monitor drain the last notes before the verdict
        @(posedge core_clk);
        @(negedge core_clk);
        final_report();
    end
endmodule : test_hardware_reset_strap_control
